// ==== common/emt_pkg.sv ====
// Package for the eight-bit match timer: register map, field layout, encodings.
// Assumes a 32-bit classic Wishbone slave at word-aligned offsets.
// Functional notes
// - Counter starts counting once one of the nine clock sources is selected.
// - External both-edge source increments on rising and falling edges.
// - Wrap from maximum to zero sets wrap flag; interrupt if enabled.
// - Count compared with both constants on each increment; equality sets match flag A or B.
// - Compare-match signal asserted in the last state of equality.
// - Match interrupt raised when the matching enable bit is one.
// - Match drives output pin to the level its select field chooses.
// - Clear mode 01 or 10 clears count on match A or B.
// - Clear mode 11 clears count on clear pin rising edge; pulse at least 1.5 clocks.
// - With trigger gate on, counting halts once any clear has happened.
// - After gated halt, selected trigger pin edge restarts counting.
// - Clear during count write wins; written value discarded.
// - Increment during count write loses; written value stored.
// - Match during constant write is suppressed; write completes.
// - Simultaneous conflicting outputs: toggle beats high beats low.
// - Internal source increments on falling edge of divided clock.
// - Switching source may cause one extra count when old high, new low.
// - Output select: 00 none, 01 low, 10 high, 11 toggle, per match.
// - Output pin is 0 after reset until first compare match.
// - Flags clear only by writing 0 after reading 1.
// - Trigger edge: 00 disabled, 01 rising, 10 falling, 11 both.
package emt_pkg;
    localparam int EMT_AW = 4;
    localparam logic [EMT_AW-1:0] EMT_OFS_CTRL0 = 4'h0;
    localparam logic [EMT_AW-1:0] EMT_OFS_CSR = 4'h1;
    localparam logic [EMT_AW-1:0] EMT_OFS_CONSTA = 4'h2;
    localparam logic [EMT_AW-1:0] EMT_OFS_CONSTB = 4'h3;
    localparam logic [EMT_AW-1:0] EMT_OFS_COUNT = 4'h4;
    localparam logic [EMT_AW-1:0] EMT_OFS_CTRL1 = 4'h5;
    // Control register zero fields
    localparam int EMT_C0_MIEB = 7;
    localparam int EMT_C0_MIEA = 6;
    localparam int EMT_C0_WIE = 5;
    localparam int EMT_C0_CLR_LO = 3;
    localparam int EMT_C0_CKS_LO = 0;
    // Control/status fields
    localparam int EMT_CS_MFB = 7;
    localparam int EMT_CS_MFA = 6;
    localparam int EMT_CS_WF = 5;
    localparam int EMT_CS_RSV = 4;
    localparam int EMT_CS_OSB_LO = 2;
    localparam int EMT_CS_OSA_LO = 0;
    // Control register one fields
    localparam int EMT_C1_TEDGE_LO = 3;
    localparam int EMT_C1_TGATE = 2;
    localparam int EMT_C1_ICKS = 0;
    localparam logic [7:0] EMT_C1_RSV_ONES = 8'hE2;
    localparam logic [7:0] EMT_CONST_RST = 8'hFF;
    localparam logic [7:0] EMT_CNT_MAX = 8'hFF;
    localparam logic [1:0] EMT_OS_NONE = 2'h0;
    localparam logic [1:0] EMT_OS_LOW = 2'h1;
    localparam logic [1:0] EMT_OS_HIGH = 2'h2;
    localparam logic [1:0] EMT_OS_TOG = 2'h3;
    localparam logic [1:0] EMT_CLR_NONE = 2'h0;
    localparam logic [1:0] EMT_CLR_MA = 2'h1;
    localparam logic [1:0] EMT_CLR_MB = 2'h2;
    localparam logic [1:0] EMT_CLR_PIN = 2'h3;
    localparam logic [1:0] EMT_TE_OFF = 2'h0;
    localparam logic [1:0] EMT_TE_RISE = 2'h1;
    localparam logic [1:0] EMT_TE_FALL = 2'h2;
    localparam logic [1:0] EMT_TE_BOTH = 2'h3;
    // Clock select {icks, cks[2:0]}
    localparam logic [2:0] EMT_CKS_EXT_RISE = 3'h5;
    localparam logic [2:0] EMT_CKS_EXT_FALL = 3'h6;
    localparam logic [2:0] EMT_CKS_EXT_BOTH = 3'h7;
    localparam int EMT_PRE_W = 13;
endpackage

// ==== verilog/emt_prescaler.sv ====
// Free-running prescaler giving divided system-clock levels.
// Assumes one clock, synchronous reset and clock enable.
`timescale 1ns/1ps
module emt_prescaler #(
    parameter int W = emt_pkg::EMT_PRE_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Divider taps
    output logic [W-1:0] div_o
);
    import emt_pkg::*;
    typedef struct packed {
        logic [W-1:0] cnt;
    } emt_pre_st_t;
    emt_pre_st_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.cnt = st_r.cnt + {{(W-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign div_o = st_r.cnt;
endmodule

// ==== verilog/emt_sync.sv ====
// Two-flop synchroniser for asynchronous pin levels.
// Assumes inputs from outside the clock domain.
`timescale 1ns/1ps
module emt_sync #(
    parameter int N = 3
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Levels
    input wire logic [N-1:0] d_i,
    output logic [N-1:0] q_o
);
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
    } emt_sync_st_t;
    emt_sync_st_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = d_i;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.s2;
endmodule

// ==== verilog/emt_timer.sv ====
// Eight-bit match timer with Wishbone register slave.
// Assumes pins are asynchronous; the bus runs on clk_i.
`timescale 1ns/1ps
module emt_timer (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [emt_pkg::EMT_AW+1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins
    input wire logic ext_clk_i,
    input wire logic clear_input_pin_i,
    input wire logic trigger_input_pin_i,
    output logic match_output_pin_o,
    // Interrupt requests to CPU
    output logic wrap_irq_o,
    output logic match_irq_a_o,
    output logic match_irq_b_o
);
    import emt_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] ca;
        logic [7:0] cb;
        logic [7:0] ctrl0;
        logic [3:0] os;
        logic [4:0] ctrl1;
        logic fa, fb, fw;
        logic ra, rb, rw;
        logic srcl;
        logic clrp, trgp;
        logic halt;
        logic eqa, eqb;
        logic pin;
        logic ack;
        logic [31:0] dat;
        logic irqw, irqa, irqb;
    } emt_st_t;
    emt_st_t st_r, st_nxt;

    logic [EMT_PRE_W-1:0] div;
    logic [2:0] pins;

    emt_prescaler #(.W(EMT_PRE_W)) u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .div_o(div)
    );

    emt_sync #(.N(3)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i({trigger_input_pin_i, clear_input_pin_i, ext_clk_i}),
        .q_o(pins)
    );

    // Source level: internal taps are divided clocks, external is the pin
    function automatic logic src_level(input logic [3:0] sel, input logic [EMT_PRE_W-1:0] d,
                                       input logic ext);
        logic r;
        r = 1'b0;
        case (sel)
            4'h1: r = d[1];
            4'h2: r = d[4];
            4'h3: r = d[5];
            4'h9: r = d[7];
            4'hA: r = d[9];
            4'hB: r = d[12];
            4'h5, 4'h6, 4'h7, 4'hD, 4'hE, 4'hF: r = ext;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    logic bus_req, bus_wr, bus_rd;
    logic [EMT_AW-1:0] idx;
    logic [3:0] csel;
    logic src, inc, both_src, rise_src;
    logic mat_a, mat_b, clr_ma, clr_mb, clr_pin, clr;
    logic trg_edge, trg_rise, trg_fall;
    logic wr_cnt, wr_ca, wr_cb, wr_c0, wr_cs, wr_c1;
    logic [1:0] osa, osb;
    logic [1:0] clrm, tedge;
    logic [7:0] csr_rd, wd;
    logic [31:0] rdat;

    always_comb begin
        bus_req = wb_cyc_i && wb_stb_i && !st_r.ack;
        bus_wr = bus_req && wb_we_i && wb_sel_i[0];
        bus_rd = bus_req && !wb_we_i;
        idx = wb_adr_i[EMT_AW+1:2];
        wd = wb_dat_i[7:0];
        wr_c0 = bus_wr && idx == EMT_OFS_CTRL0;
        wr_cs = bus_wr && idx == EMT_OFS_CSR;
        wr_ca = bus_wr && idx == EMT_OFS_CONSTA;
        wr_cb = bus_wr && idx == EMT_OFS_CONSTB;
        wr_cnt = bus_wr && idx == EMT_OFS_COUNT;
        wr_c1 = bus_wr && idx == EMT_OFS_CTRL1;
        osa = st_r.os[EMT_CS_OSA_LO +: 2];
        osb = st_r.os[EMT_CS_OSB_LO +: 2];
        clrm = st_r.ctrl0[EMT_C0_CLR_LO +: 2];
        tedge = st_r.ctrl1[EMT_C1_TEDGE_LO +: 2];
        csel = {st_r.ctrl1[EMT_C1_ICKS], st_r.ctrl0[EMT_C0_CKS_LO +: 3]};
        src = src_level(csel, div, pins[0]);
        both_src = csel[2:0] == EMT_CKS_EXT_BOTH;
        rise_src = csel[2:0] == EMT_CKS_EXT_RISE;
        // Falling edge counts for internal taps; a switch from high to low counts once
        inc = csel[2:0] != 3'h0 && csel[2:0] != 3'h4 && !st_r.halt &&
              (both_src ? (src != st_r.srcl) :
               rise_src ? (src && !st_r.srcl) : (!src && st_r.srcl));
        // Match on the increment leaving equality, so its last state is sampled; clear in the same cycle
        mat_a = st_r.cnt == st_r.ca && !wr_ca && inc;
        mat_b = st_r.cnt == st_r.cb && !wr_cb && inc;
        clr_ma = clrm == EMT_CLR_MA && mat_a;
        clr_mb = clrm == EMT_CLR_MB && mat_b;
        clr_pin = clrm == EMT_CLR_PIN && pins[1] && !st_r.clrp;
        clr = clr_ma || clr_mb || clr_pin;
        trg_rise = pins[2] && !st_r.trgp;
        trg_fall = !pins[2] && st_r.trgp;
        trg_edge = (tedge == EMT_TE_RISE && trg_rise) || (tedge == EMT_TE_FALL && trg_fall) ||
                   (tedge == EMT_TE_BOTH && (trg_rise || trg_fall));
        csr_rd = 8'h00;
        csr_rd[EMT_CS_MFB] = st_r.fb;
        csr_rd[EMT_CS_MFA] = st_r.fa;
        csr_rd[EMT_CS_WF] = st_r.fw;
        csr_rd[EMT_CS_RSV] = 1'b1;
        csr_rd[3:0] = st_r.os;
        case (idx)
            EMT_OFS_CTRL0: rdat = {24'h000000, st_r.ctrl0};
            EMT_OFS_CSR: rdat = {24'h000000, csr_rd};
            EMT_OFS_CONSTA: rdat = {24'h000000, st_r.ca};
            EMT_OFS_CONSTB: rdat = {24'h000000, st_r.cb};
            EMT_OFS_COUNT: rdat = {24'h000000, st_r.cnt};
            EMT_OFS_CTRL1: rdat = {24'h000000, EMT_C1_RSV_ONES | {3'h0, st_r.ctrl1}};
            default: rdat = 32'h00000000;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.srcl = src;
        st_nxt.clrp = pins[1];
        st_nxt.trgp = pins[2];
        st_nxt.ack = bus_req;
        st_nxt.dat = bus_rd ? rdat : 32'h00000000;
        // Clear beats write beats increment
        if (clr) begin
            st_nxt.cnt = 8'h00;
        end else if (wr_cnt) begin
            st_nxt.cnt = wd;
        end else if (inc) begin
            st_nxt.cnt = st_r.cnt + 8'h01;
        end
        if (clr && st_r.ctrl1[EMT_C1_TGATE]) begin
            st_nxt.halt = 1'b1;
        end else if (st_r.halt && (trg_edge || !st_r.ctrl1[EMT_C1_TGATE])) begin
            st_nxt.halt = 1'b0;
        end
        if (wr_ca) st_nxt.ca = wd;
        if (wr_cb) st_nxt.cb = wd;
        if (wr_c0) st_nxt.ctrl0 = wd;
        if (wr_c1) st_nxt.ctrl1 = wd[4:0];
        if (bus_rd && idx == EMT_OFS_CSR) begin
            st_nxt.ra = st_r.fa;
            st_nxt.rb = st_r.fb;
            st_nxt.rw = st_r.fw;
        end
        if (wr_cs) begin
            st_nxt.os = wd[3:0];
            // Write 0 after reading 1 clears; set wins below
            if (!wd[EMT_CS_MFA] && st_r.ra) st_nxt.fa = 1'b0;
            if (!wd[EMT_CS_MFB] && st_r.rb) st_nxt.fb = 1'b0;
            if (!wd[EMT_CS_WF] && st_r.rw) st_nxt.fw = 1'b0;
            st_nxt.ra = 1'b0;
            st_nxt.rb = 1'b0;
            st_nxt.rw = 1'b0;
        end
        if (mat_a) st_nxt.fa = 1'b1;
        if (mat_b) st_nxt.fb = 1'b1;
        if (inc && !clr && !wr_cnt && st_r.cnt == EMT_CNT_MAX) st_nxt.fw = 1'b1;
        // Priority toggle, high, low
        if ((mat_a && osa == EMT_OS_TOG) || (mat_b && osb == EMT_OS_TOG)) begin
            st_nxt.pin = !st_r.pin;
        end else if ((mat_a && osa == EMT_OS_HIGH) || (mat_b && osb == EMT_OS_HIGH)) begin
            st_nxt.pin = 1'b1;
        end else if ((mat_a && osa == EMT_OS_LOW) || (mat_b && osb == EMT_OS_LOW)) begin
            st_nxt.pin = 1'b0;
        end
        st_nxt.irqw = st_nxt.fw && st_r.ctrl0[EMT_C0_WIE];
        st_nxt.irqa = st_nxt.fa && st_r.ctrl0[EMT_C0_MIEA];
        st_nxt.irqb = st_nxt.fb && st_r.ctrl0[EMT_C0_MIEB];
        st_nxt.eqa = mat_a;
        st_nxt.eqb = mat_b;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.ca <= EMT_CONST_RST;
            st_r.cb <= EMT_CONST_RST;
            st_r.pin <= 1'b0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.dat;
    assign match_output_pin_o = st_r.pin;
    assign wrap_irq_o = st_r.irqw;
    assign match_irq_a_o = st_r.irqa;
    assign match_irq_b_o = st_r.irqb;

    a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && st_r.ack |=> !st_r.ack) else $error("ack held two cycles");
    a_flag_a_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && mat_a |=> st_r.fa) else $error("match flag a not set");
    a_wrap_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && inc && !clr && !wr_cnt && st_r.cnt == 8'hFF |=> st_r.fw && st_r.cnt == 8'h00)
        else $error("wrap not flagged");
    a_clear_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && clr |=> st_r.cnt == 8'h00) else $error("clear lost");
    a_write_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_cnt && !clr |=> st_r.cnt == $past(wb_dat_i[7:0])) else $error("write lost");
    a_const_supp: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ca |-> !mat_a) else $error("match during write");
    a_none_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        clrm == EMT_CLR_NONE |-> !clr) else $error("clear in mode none");
    a_gate_halt: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && clr && st_r.ctrl1[EMT_C1_TGATE] |=> st_r.halt) else $error("no halt");
    // Next flag value, since a flag cleared in this cycle drops its request too
    a_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && st_nxt.fa && st_r.ctrl0[EMT_C0_MIEA] |=> match_irq_a_o) else $error("irq a");
    a_irq_b: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && st_nxt.fb && st_r.ctrl0[EMT_C0_MIEB] |=> match_irq_b_o)
        else $error("irq b");
    a_irq_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && st_nxt.fw && st_r.ctrl0[EMT_C0_WIE] |=> wrap_irq_o)
        else $error("wrap irq");
    a_flag_b_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && mat_b |=> st_r.fb)
        else $error("match flag b not set");
    a_pin_reset: assert property (@(posedge clk_i)
        $past(rst_i) && !rst_i |-> !match_output_pin_o)
        else $error("pin not low after reset");
    a_clear_ma: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && clrm == EMT_CLR_MA && mat_a |=> st_r.cnt == 8'h00)
        else $error("no clear on match a");
    a_clear_mb: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && clrm == EMT_CLR_MB && mat_b |=> st_r.cnt == 8'h00)
        else $error("no clear on match b");
    a_pin_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && clrm == EMT_CLR_PIN && pins[1] && !st_r.clrp |=> st_r.cnt == 8'h00)
        else $error("no clear on pin edge");
    a_trig_resume: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && st_r.halt && trg_edge && !clr |=> !st_r.halt)
        else $error("trigger did not restart");
    a_halt_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r.halt |-> !inc)
        else $error("count while halted");
    a_trig_off: assert property (@(posedge clk_i) disable iff (rst_i)
        tedge == EMT_TE_OFF |-> !trg_edge)
        else $error("trigger while disabled");
    a_pin_high: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && mat_a && osa == EMT_OS_HIGH && !(mat_b && osb == EMT_OS_TOG) |=> st_r.pin)
        else $error("pin not driven high");
    a_pin_low: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && mat_a && osa == EMT_OS_LOW && !mat_b |=> !st_r.pin)
        else $error("pin not driven low");
    a_pin_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !mat_a && !mat_b |=> $stable(st_r.pin))
        else $error("pin moved without match");
    a_flag_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_cs && !wd[EMT_CS_MFA] && !st_r.ra && st_r.fa |=> st_r.fa)
        else $error("flag cleared without read");
    a_stop_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        csel[2:0] == 3'h0 |-> !inc)
        else $error("count with no source");
    a_count_inc: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && inc && !clr && !wr_cnt |=> st_r.cnt == $past(st_r.cnt) + 8'h01)
        else $error("increment lost");
    a_both_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        both_src && !st_r.halt && src != st_r.srcl |-> inc)
        else $error("both-edge count missed");
    a_toggle_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && mat_a && osa == EMT_OS_TOG |=> st_r.pin != $past(st_r.pin))
        else $error("no toggle");
    c_wrap: cover property (@(posedge clk_i) st_r.fw);
    c_match_b: cover property (@(posedge clk_i) mat_b);
    c_pin_clear: cover property (@(posedge clk_i) clr_pin);
    c_trig_restart: cover property (@(posedge clk_i) st_r.halt && trg_edge);
endmodule

// ==== bench/emt_pin_model.sv ====
// Pin-side partner: external count clock, clear pulse and trigger level.
// Assumes the bench requests activity on clk_i rising edges.
`timescale 1ns/1ps
module emt_pin_model (
    // Clock
    input wire logic clk_i,
    // Requests from the bench
    input wire logic ext_run_i,
    input wire logic clr_req_i,
    input wire logic trg_lvl_i,
    // Pins
    output logic ext_clk_o,
    output logic clear_pin_o,
    output logic trigger_pin_o
);
    logic [1:0] div_r = 2'h0;
    logic [1:0] clr_cnt_r = 2'h0;
    initial ext_clk_o = 1'b0;
    // Stands low outside a burst, like a gated source
    always @(posedge clk_i) begin
        div_r <= div_r + 2'h1;
        if (!ext_run_i)
            ext_clk_o <= 1'b0;
        else if (div_r == 2'h3)
            ext_clk_o <= ~ext_clk_o;
    end
    // Three clocks high, well over the minimum width
    always @(posedge clk_i) begin
        if (clr_req_i)
            clr_cnt_r <= 2'h3;
        else if (clr_cnt_r != 2'h0)
            clr_cnt_r <= clr_cnt_r - 2'h1;
    end
    assign clear_pin_o = (clr_cnt_r != 2'h0);
    assign trigger_pin_o = trg_lvl_i;
endmodule

// ==== bench/test_eight_bit_match_timer.sv ====
// Self-checking bench for the eight-bit match timer.
// Assumes the Wishbone map of emt_pkg and the pin model beside it.
`timescale 1ns/1ps
module test_eight_bit_match_timer;
    import emt_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [5:0] wb_adr = 6'h00;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack, ext_clk, clr_pin, trg_pin, pin_o, wrap_irq, irq_a, irq_b;
    logic ext_run = 1'b0;
    logic clr_req = 1'b0;
    logic trg_lvl = 1'b0;
    logic [31:0] seed = 32'd1000;
    int error_cnt = 0;
    int compares = 0;
    int edges = 0;
    logic [7:0] rd, c;
    logic pin_exp;
    always #50 clk_i = ~clk_i;
    always @(ext_clk) edges++;
    emt_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .ext_clk_i(ext_clk), .clear_input_pin_i(clr_pin),
        .trigger_input_pin_i(trg_pin), .match_output_pin_o(pin_o),
        .wrap_irq_o(wrap_irq), .match_irq_a_o(irq_a), .match_irq_b_o(irq_b));
    emt_pin_model pins (.clk_i(clk_i), .ext_run_i(ext_run), .clr_req_i(clr_req),
        .trg_lvl_i(trg_lvl), .ext_clk_o(ext_clk), .clear_pin_o(clr_pin),
        .trigger_pin_o(trg_pin));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic exp_pin(input logic old, input logic [1:0] a,
                                     input logic [1:0] b);
        if (a == EMT_OS_TOG || b == EMT_OS_TOG) return ~old;
        if (a == EMT_OS_HIGH || b == EMT_OS_HIGH) return 1'b1;
        if (a == EMT_OS_LOW || b == EMT_OS_LOW) return 1'b0;
        return old;
    endfunction
    task automatic test_done();
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= {idx, 2'b00};
        wb_wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            test_done();
        end
        rd = wb_rdat[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask
    task automatic wait_irq(input bit w);
        int k;
        k = 0;
        while ((w ? wrap_irq : irq_a) !== 1'b1 && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 400) begin
            error_cnt++;
            test_done();
        end
    endtask
    initial begin
        #5000000;
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(EMT_OFS_CTRL0, 8'h00);
        rdc(EMT_OFS_CSR, 8'h10);
        rdc(EMT_OFS_CONSTA, EMT_CONST_RST);
        rdc(EMT_OFS_CONSTB, EMT_CONST_RST);
        rdc(EMT_OFS_COUNT, 8'h00);
        rdc(EMT_OFS_CTRL1, EMT_C1_RSV_ONES);
        rdc(4'h6, 8'h00);
        check({7'h0, pin_o}, 8'h00);
        wr(EMT_OFS_COUNT, 8'hFE);
        wr(EMT_OFS_CTRL0, 8'h21);
        wait_irq(1'b1);
        wr(EMT_OFS_CTRL0, 8'h20);
        // Zero written before reading the flag as 1 must not clear it
        wr(EMT_OFS_CSR, 8'h00);
        // Passing FF also matches both reset constants
        rdc(EMT_OFS_CSR, 8'hF0);
        wr(EMT_OFS_CSR, 8'h00);
        rdc(EMT_OFS_CSR, 8'h10);
        check({7'h0, wrap_irq}, 8'h00);
        pin_exp = 1'b0;
        for (int i = 0; i < 16; i++) begin
            c = 8'h20 | (rnd() & 8'h3F);
            wr(EMT_OFS_CONSTA, c);
            wr(EMT_OFS_CONSTB, c);
            wr(EMT_OFS_COUNT, c - 8'h03);
            wr(EMT_OFS_CSR, {4'h0, i[3:0]});
            wr(EMT_OFS_CTRL0, {3'b110, (i[0] ? EMT_CLR_MB : EMT_CLR_MA), 3'h1});
            wait_irq(1'b0);
            wr(EMT_OFS_CTRL0, 8'hC0);
            pin_exp = exp_pin(pin_exp, i[1:0], i[3:2]);
            check({7'h0, pin_o}, {7'h0, pin_exp});
            check({6'h0, irq_a, irq_b}, 8'h03);
            bus(1'b0, EMT_OFS_COUNT, 8'h00);
            check({7'h0, rd < 8'h08}, 8'h01);
            rdc(EMT_OFS_CSR, 8'hD0 | {4'h0, i[3:0]});
            wr(EMT_OFS_CSR, {4'h0, i[3:0]});
        end
        wr(EMT_OFS_CONSTA, 8'h10);
        wr(EMT_OFS_COUNT, 8'h0E);
        wr(EMT_OFS_CTRL0, 8'h41);
        wait_irq(1'b0);
        wr(EMT_OFS_CTRL0, 8'h00);
        bus(1'b0, EMT_OFS_COUNT, 8'h00);
        check({7'h0, rd > 8'h10}, 8'h01);
        bus(1'b0, EMT_OFS_CSR, 8'h00);
        wr(EMT_OFS_CSR, 8'h00);
        for (int m = 0; m < 2; m++) begin
            wr(EMT_OFS_COUNT, 8'h00);
            wr(EMT_OFS_CTRL0, {5'h0, (m ? EMT_CKS_EXT_BOTH : EMT_CKS_EXT_RISE)});
            edges = 0;
            ext_run <= 1'b1;
            repeat (32 + int'(rnd() & 8'h1F)) @(posedge clk_i);
            ext_run <= 1'b0;
            repeat (8) @(posedge clk_i);
            wr(EMT_OFS_CTRL0, 8'h00);
            bus(1'b0, EMT_OFS_COUNT, 8'h00);
            check(rd, m ? 8'(edges) : 8'((edges + 1) / 2));
        end
        for (int t = 0; t < 4; t++) begin
            wr(EMT_OFS_CTRL1, {3'h0, t[1:0], 3'b100});
            rdc(EMT_OFS_CTRL1, EMT_C1_RSV_ONES | {3'h0, t[1:0], 3'b100});
            wr(EMT_OFS_CTRL0, 8'h19);
            repeat (20) @(posedge clk_i);
            clr_req <= 1'b1;
            @(posedge clk_i);
            clr_req <= 1'b0;
            repeat (20) @(posedge clk_i);
            rdc(EMT_OFS_COUNT, 8'h00);
            trg_lvl <= 1'b1;
            repeat (30) @(posedge clk_i);
            bus(1'b0, EMT_OFS_COUNT, 8'h00);
            check({7'h0, rd != 8'h00}, {7'h0, t[0]});
            trg_lvl <= 1'b0;
            repeat (30) @(posedge clk_i);
            bus(1'b0, EMT_OFS_COUNT, 8'h00);
            check({7'h0, rd != 8'h00}, {7'h0, t != 0});
            wr(EMT_OFS_CTRL0, 8'h00);
        end
        test_done();
    end
endmodule
